// ---- verilog/spm_pkg.sv ----
package spm_pkg;
    // result word size
    localparam int unsigned RESULT_W = 16;
    // chain pass-through delay in serial clock cycles
    localparam int unsigned CHAIN_DELAY = 16;

    // pin indices inside the synchronised pin bundle
    localparam int unsigned PIN_W = 3;
    localparam int unsigned PIN_SCK = 0;
    localparam int unsigned PIN_START = 1;
    localparam int unsigned PIN_CHAIN = 2;

    // values after reset
    localparam logic [RESULT_W-1:0] SHREG_RESET = 16'h0000;
    localparam logic [PIN_W-1:0] PINS_RESET = 3'h0;
    localparam logic CHAIN_RESET = 1'b0;

    // phase of the read-out port
    typedef enum logic [1:0] {
        SPM_PH_IDLE,
        SPM_PH_CONV,
        SPM_PH_DATA
    } spm_phase_e;
endpackage

// ---- verilog/spm_pin_if.sv ----
`timescale 1ns/1ps
interface spm_pin_if;
    logic [spm_pkg::PIN_W-1:0] level;
    logic [spm_pkg::PIN_W-1:0] rise;
    logic [spm_pkg::PIN_W-1:0] fall;

    // synchroniser side
    modport src (
        output level,
        output rise,
        output fall
    );

    // port logic side
    modport dst (
        input level,
        input rise,
        input fall
    );
endinterface

// ---- verilog/spm_pin_sync.sv ----
`timescale 1ns/1ps
module spm_pin_sync (
    // clock and reset
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_i,
    // raw pins
    input  wire logic [spm_pkg::PIN_W-1:0] pins_i,
    // synchronised levels and edges
    spm_pin_if.src                         pin_bus
);
    typedef struct packed {
        logic [spm_pkg::PIN_W-1:0] meta;
        logic [spm_pkg::PIN_W-1:0] sync;
        logic [spm_pkg::PIN_W-1:0] prev;
    } spm_sync_s;

    spm_sync_s st_reg;
    spm_sync_s st_next;

    // two-flop synchroniser plus one history stage
    always_comb begin
        st_next      = st_reg;
        st_next.meta = pins_i;
        st_next.sync = st_reg.meta;
        st_next.prev = st_reg.sync;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_reg <= '{spm_pkg::PINS_RESET, spm_pkg::PINS_RESET, spm_pkg::PINS_RESET};
        end else begin
            st_reg <= st_next;
        end
    end

    // edges seen only after the second stage
    genvar g;
    generate
        for (g = 0; g < spm_pkg::PIN_W; g++) begin : g_edge
            assign pin_bus.level[g] = st_reg.sync[g];
            assign pin_bus.rise[g]  = st_reg.sync[g] & ~st_reg.prev[g];
            assign pin_bus.fall[g]  = ~st_reg.sync[g] & st_reg.prev[g];
        end
    endgenerate
endmodule

// ---- verilog/spm_serial_port.sv ----
`timescale 1ns/1ps
module spm_serial_port (
    // clock and reset
    input  wire logic                         ref_clk_i,
    input  wire logic                         rst_i,
    // link pins
    input  wire logic                         sck_i,
    input  wire logic                         conversion_start_in_i,
    input  wire logic                         chain_data_in_i,
    output logic                              serial_result_out_o,
    output logic                              serial_result_oe_o,
    // converter core
    output logic                              conv_start_o,
    input  wire logic                         conv_done_i,
    input  wire logic [spm_pkg::RESULT_W-1:0] result_i,
    // status
    output logic                              chain_mode_o
);
    typedef struct packed {
        spm_pkg::spm_phase_e               phase;
        logic                              chain;
        logic                              busy_hi;
        logic                              chain_cap;
        logic [spm_pkg::RESULT_W-1:0]      shreg;
        logic                              out_bit;
        logic                              oe;
        logic                              start;
    } spm_port_s;

    spm_port_s st_reg;
    spm_port_s st_next;

    spm_pin_if pins ();

    logic sck_rise;
    logic sck_fall;
    logic start_rise;
    logic start_lvl;
    logic chain_lvl;
    logic cs_select;
    logic shift_ok;

    // pins pass two flops before any logic looks at them
    spm_pin_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .pins_i    ({chain_data_in_i, conversion_start_in_i, sck_i}),
        .pin_bus   (pins)
    );

    // decoded link events
    assign sck_rise  = pins.rise[spm_pkg::PIN_SCK];
    assign sck_fall  = pins.fall[spm_pkg::PIN_SCK];
    assign start_rise = pins.rise[spm_pkg::PIN_START];
    assign start_lvl  = pins.level[spm_pkg::PIN_START];
    assign chain_lvl  = pins.level[spm_pkg::PIN_CHAIN];
    assign cs_select  = ~start_lvl | ~chain_lvl;
    // chain mode reads while start is high, cs mode while selected
    assign shift_ok   = st_reg.chain ? start_lvl : cs_select;

    // next-state logic of the read-out port
    always_comb begin
        st_next       = st_reg;
        st_next.start = 1'b0;
        if (start_rise) begin
            st_next.chain   = ~chain_lvl;
            st_next.phase   = spm_pkg::SPM_PH_CONV;
            st_next.busy_hi = 1'b0;
            st_next.start   = 1'b1;
        end else begin
            // sample chain input on the host's rising edge
            if (sck_rise) begin
                st_next.chain_cap = chain_lvl;
            end
            case (st_reg.phase)
                spm_pkg::SPM_PH_IDLE: begin
                    st_next.phase = spm_pkg::SPM_PH_IDLE;
                end
                spm_pkg::SPM_PH_CONV: begin
                    if (conv_done_i) begin
                        st_next.shreg   = result_i;
                        st_next.phase   = spm_pkg::SPM_PH_DATA;
                        st_next.busy_hi = ~st_reg.chain & cs_select;
                    end
                end
                spm_pkg::SPM_PH_DATA: begin
                    if (sck_fall && shift_ok) begin
                        if (st_reg.busy_hi) begin
                            st_next.busy_hi = 1'b0; // busy marker consumed
                        end else begin
                            // chain bit walks 16 stages to the output
                            st_next.shreg = {st_reg.shreg[spm_pkg::RESULT_W-2:0],
                                             st_reg.chain_cap};
                        end
                    end
                end
                default: begin
                    st_next.phase = spm_pkg::SPM_PH_IDLE;
                end
            endcase
        end
        // output bit: low while converting in cs mode, busy marker high, then msb first
        if (st_next.phase == spm_pkg::SPM_PH_CONV && !st_next.chain) begin
            st_next.out_bit = 1'b0;
        end else if (st_next.busy_hi) begin
            st_next.out_bit = 1'b1;
        end else begin
            st_next.out_bit = st_next.shreg[spm_pkg::RESULT_W-1];
        end
        // output enable
        if (st_next.chain) begin
            st_next.oe = 1'b1;
        end else begin
            st_next.oe = cs_select;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_reg <= '{spm_pkg::SPM_PH_IDLE, spm_pkg::CHAIN_RESET, 1'b0, 1'b0,
                        spm_pkg::SHREG_RESET, 1'b0, 1'b0, 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state flops
    assign serial_result_out_o = st_reg.out_bit;
    assign serial_result_oe_o  = st_reg.oe;
    assign conv_start_o        = st_reg.start;
    assign chain_mode_o        = st_reg.chain;

    // checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_start_pulse;
        conv_start_o ##1 !conv_start_o;
    endsequence

    sequence s_data_shift;
        sck_fall && shift_ok && st_reg.phase == spm_pkg::SPM_PH_DATA && !st_reg.busy_hi;
    endsequence

    a_start_pulse: assert property (start_rise |=> s_start_pulse)
        else $error("conversion start pulse missing");

    a_chain_select: assert property (start_rise && !chain_lvl |=> chain_mode_o)
        else $error("chain mode not latched");

    a_cs_select: assert property (start_rise && chain_lvl |=> !chain_mode_o)
        else $error("chip-select mode not latched");

    a_cs_enable: assert property (!start_rise && !st_reg.chain |=>
                                  serial_result_oe_o == $past(cs_select))
        else $error("chip-select output enable wrong");

    a_chain_drive: assert property (!start_rise && st_reg.chain |=> serial_result_oe_o)
        else $error("chain mode output not driven");

    a_shift_step: assert property ((s_data_shift and !start_rise) |=>
                                   st_reg.shreg == {$past(st_reg.shreg[14:0]),
                                                    $past(st_reg.chain_cap)})
        else $error("result register did not shift");

    a_load_result: assert property (!start_rise && st_reg.phase == spm_pkg::SPM_PH_CONV
                                    && conv_done_i |=> st_reg.shreg == $past(result_i))
        else $error("result not loaded");

    a_msb_out: assert property (st_reg.phase == spm_pkg::SPM_PH_DATA && !st_reg.busy_hi
                                |-> serial_result_out_o == st_reg.shreg[15])
        else $error("output bit is not the register msb");

    a_busy_flag: assert property (!start_rise && st_reg.phase == spm_pkg::SPM_PH_CONV
                                  && conv_done_i && !st_reg.chain && cs_select
                                  |=> st_reg.busy_hi ##0 serial_result_out_o)
        else $error("busy indication not raised");

    a_chain_hold: assert property ((s_data_shift and st_reg.chain) |-> start_lvl)
        else $error("chain shift without conversion start high");
endmodule

// ---- tb/spm_core_model.sv ----
`timescale 1ns/1ps
// converter core stand-in: a done pulse a fixed time after each start
module spm_core_model #(
    parameter int DELAY = 40
) (
    // clock
    input  wire logic                         ref_clk_i,
    // handshake with the port
    input  wire logic                         conv_start_i,
    input  wire logic [spm_pkg::RESULT_W-1:0] value_i,
    output logic                              conv_done_o,
    output logic [spm_pkg::RESULT_W-1:0]      result_o
);
    int cnt = -1;
    initial conv_done_o = 1'b0;
    initial result_o = '0;
    // countdown; result changes only with done, so it never looks stale
    always @(posedge ref_clk_i) begin
        conv_done_o <= (cnt == 0);
        if (cnt == 0) result_o <= value_i;
        if (conv_start_i) cnt <= DELAY;
        else if (cnt >= 0) cnt <= cnt - 1;
    end
endmodule

// ---- tb/spm_serial_port_tb.sv ----
`timescale 1ns/1ps
module spm_serial_port_tb;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        sck = 1'b0, conv_pin = 1'b0, chain_pin = 1'b1;
    logic        out, oe, start, done, cmode, d;
    logic [15:0] value = '0, res;
    logic [31:0] lfsr_reg = 32'hd2b1;
    int          n_mismatch = 0, cmp_count = 0, cycles = 0, n_start = 0, n;
    int          q[$];

    // clock, start-pulse count, run limit
    always #10 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        if (start === 1'b1) n_start++;
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            final_report();
        end
    end

    spm_serial_port u_spm_serial_port (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sck_i(sck),
        .conversion_start_in_i(conv_pin), .chain_data_in_i(chain_pin), .serial_result_out_o(out),
        .serial_result_oe_o(oe), .conv_start_o(start), .conv_done_i(done), .result_i(res),
        .chain_mode_o(cmode));
    spm_core_model u_spm_core_model (.ref_clk_i(ref_clk_i), .conv_start_i(start),
        .value_i(value), .conv_done_o(done), .result_o(res));

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk_i);
    endtask
    task automatic pins(input logic c, input logic s);
        @(posedge ref_clk_i);
        conv_pin <= c;
        chain_pin <= s;
    endtask
    task automatic check_bit(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // kind 0: select busy, 1: select no busy, 2: chain
    task automatic frame(input int kind);
        int s0;
        pins(1'b0, kind != 2);
        tick(8);
        lfsr_reg = lfsr_step(lfsr_reg);
        value <= lfsr_reg[15:0];
        s0 = n_start;
        pins(1'b1, kind != 2);
        tick(8);
        check_bit(cmode, kind == 2, "mode");
        check_bit(n_start == s0 + 1, 1'b1, "start");
        if (kind == 0) pins(1'b1, 1'b0);
        tick(60);
        if (kind == 0) q.push_back(1);
        for (int i = 15; i >= 0; i--) q.push_back(value[i]);
        // chain level at the first sck rise follows the result bits
        if (kind == 2) q.push_back(chain_pin);
        if (kind == 1) begin
            check_bit(oe, 1'b0, "released");
            pins(1'b0, 1'b1);
            tick(6);
        end
        n = (kind == 2) ? 32 : q.size();
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk_i) sck <= 1'b1;
            tick(3);
            check_bit(out, q.pop_front(), "data");
            check_bit(oe, 1'b1, "driven");
            @(posedge ref_clk_i) sck <= 1'b0;
            if (kind == 2 && i < 15) begin
                lfsr_reg = lfsr_step(lfsr_reg);
                d = lfsr_reg[0];
                chain_pin <= d;
                q.push_back(d);
            end
            tick(3);
        end
        pins(1'b1, 1'b1);
        tick(6);
        if (kind != 2) check_bit(oe, 1'b0, "released");
    endtask

    // reset, then each kind twice; chain host keeps conversion start high
    initial begin
        tick(2);
        rst_i <= 1'b0;
        tick(4);
        for (int r = 0; r < 6; r++) begin
            frame(r % 3);
        end
        final_report();
    end
endmodule
